/* rtl/hbi_pkg.sv */
// host bus interface package: constants and carrier types
// assumes one system clock at 200 MHz; internal phase is clock divided by two
package hbi_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DMA_W = 16;
  localparam int CHAN_W = 2;
  localparam int NUM_CHAN = 3;
  localparam int CLK_PERIOD_NS = 5;
  // internal clock is system clock divided by this
  localparam int CLK_DIV = 2;
  // hold-off after end-of-service write, in ns, and as a cycle count
  localparam int EOS_HOLD_NS = 1000;
  localparam int EOS_HOLD_CYC = EOS_HOLD_NS / CLK_PERIOD_NS;
  // map: live-hardware locations, the rest is register RAM
  localparam logic [ADDR_W-1:0] ADR_CHAN_PTR = 7'h68;
  localparam logic [ADDR_W-1:0] ADR_END_SVC = 7'h60;
  localparam logic [ADDR_W-1:0] ADR_SVC_REQ = 7'h67;
  localparam logic [ADDR_W-1:0] ADR_MODEM_IN = 7'h6C;
  localparam logic [ADDR_W-1:0] ADR_VECTOR = 7'h70;
  // addresses at or above this are global, below it are per channel
  localparam logic [ADDR_W-1:0] ADR_GLOBAL_BASE = 7'h40;
  localparam logic [CHAN_W-1:0] CHAN_PARALLEL = 2'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_ACK  = 5'b01000,
    ST_WAIT = 5'b10000
  } hbi_state_t;

  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic svc_ack_n;
    logic rd_wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hbi_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic drive;
    logic ack_n;
  } hbi_rsp_t;
endpackage : hbi_pkg

/* rtl/hbi_clkdiv.sv */
// divide-by-two phase generator for the internal clock
// assumes a free-running system clock and async active-low reset
`default_nettype none
module hbi_clkdiv import hbi_pkg::*; #(
  parameter int DIV = CLK_DIV
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  output logic rise // one-cycle rising edge of divided clock
);
  logic [3:0] cnt_q;
  // the phase counter is four bits wide
  if (DIV < 2 || DIV > 16) begin : g_bad_div
    $error("hbi_clkdiv: DIV out of range");
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (ce) begin
      cnt_q <= (cnt_q == 4'(DIV - 1)) ? 4'h0 : cnt_q + 4'h1;
    end
  end
  assign rise = ce && (cnt_q == 4'(DIV - 1));
endmodule // hbi_clkdiv
`default_nettype wire

/* rtl/hbi_host_port.sv */
// host cpu bus slave: strobed 8-bit register port with transfer acknowledge
// assumes host inputs synchronous to clk; dma port handled elsewhere
`default_nettype none
// ============================================================
// Functional notes
// - channel pointer picks the channel set later accesses reach
// - channel pointer zero maps channel addresses onto the parallel set
// - internal sequencing runs on system clock divided by two
// - strobes, address, write data sampled on internal clock rising edges
// - detected cycle runs a fixed sequence with predictable capture points
// - acknowledge ends every non-dma cycle, never dma transfers
// - late strobes slip recognition by two full system clock cycles
// - read starts only with select or service-ack low and strobe low, read line high
// - timing starts from the later strobe; one strobe alone does nothing
// - read drives register data then asserts acknowledge
// - cycle holds data and acknowledge until both strobes are removed
// - write uses same strobes with read line low; ack after data taken
// - port has 8-bit data, 7-bit address and 16-bit dma port
// - most addresses are ram; some map to live hardware
// - service-ack read returns vector of acknowledged request type
// - after end-of-service write, next cycle stalls about one microsecond
module hbi_host_port import hbi_pkg::*; #(
  parameter int EOS_CYC = EOS_HOLD_CYC
) (
  input wire logic clk, // system clock, 200 MHz
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire hbi_req_t req, // host strobes, address, write data
  input wire logic dma_ack_n, // dma acknowledge, active low
  input wire logic [DMA_W-1:0] dma_in, // dma port input
  input wire logic [DATA_W-1:0] svc_req_in, // live service-request bits
  input wire logic [DATA_W-1:0] modem_in, // live modem pin states
  input wire logic [DATA_W-1:0] vector_in, // vector of acknowledged request
  output hbi_rsp_t rsp, // read data, drive enable, acknowledge
  output logic [CHAN_W-1:0] chan_ptr_q, // current channel pointer
  output logic parallel_sel_q, // channel pointer selects parallel set
  output logic eos_pulse_q // end-of-service write seen
);
  localparam int CNT_W = $clog2(EOS_CYC + 1);
  // every pointer value owns a window, so a stray pointer never
  // aliases the global block; costs one spare window of flops
  localparam int WIN_N = 2 ** CHAN_W;
  localparam int RAM_N = (WIN_N + 1) * 64;
  localparam int IDX_W = $clog2(RAM_N);
  if (EOS_CYC < 1 || EOS_CYC > 65535) begin : g_bad_eos
    $error("hbi_host_port: EOS_CYC out of range");
  end

  // ============================================================
  // internal clock phase
  logic phase_rise;
  hbi_clkdiv #(.DIV(CLK_DIV)) u_div (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .rise(phase_rise)
  );

  // ============================================================
  // request sampling
  // strobes are only looked at on a divided-clock edge, so a request
  // missing one edge waits a full internal period: two system clocks
  logic sel_now, strobes_off;
  assign sel_now = (!req.cs_n || !req.svc_ack_n) && !req.ds_n;
  assign strobes_off = req.cs_n && req.svc_ack_n && req.ds_n;

  hbi_state_t state_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic is_rd_q, is_svc_q;
  logic [CNT_W-1:0] hold_q;
  logic [DATA_W-1:0] ram_q [RAM_N];
  logic [IDX_W-1:0] ram_idx;

  // global addresses bypass the channel window
  always_comb begin
    if (addr_q >= ADR_GLOBAL_BASE) begin
      ram_idx = IDX_W'(WIN_N * 64) + IDX_W'(addr_q[5:0]);
    end else begin
      ram_idx = IDX_W'({chan_ptr_q, addr_q[5:0]});
    end
  end

  // ============================================================
  // cycle sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      addr_q <= 7'h00;
      wdata_q <= RST_DATA;
      is_rd_q <= 1'b0;
      is_svc_q <= 1'b0;
    end else if (ce && phase_rise) begin
      case (state_q)
        ST_IDLE: begin
          // dma acknowledge never opens a register cycle
          if (sel_now && dma_ack_n && hold_q == '0) begin
            state_q <= ST_ADDR;
            addr_q <= req.addr;
            is_rd_q <= req.rd_wr_n;
            is_svc_q <= req.cs_n;
          end
        end
        ST_ADDR: begin
          wdata_q <= req.wdata;
          state_q <= ST_DATA;
        end
        ST_DATA: begin
          state_q <= ST_ACK;
        end
        ST_ACK: begin
          if (strobes_off) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (strobes_off) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // register storage and channel pointer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_ptr_q <= CHAN_PARALLEL;
      parallel_sel_q <= 1'b1;
      eos_pulse_q <= 1'b0;
    end else if (ce) begin
      eos_pulse_q <= 1'b0;
      if (phase_rise && state_q == ST_DATA && !is_rd_q && !is_svc_q) begin
        if (addr_q == ADR_CHAN_PTR) begin
          chan_ptr_q <= wdata_q[CHAN_W-1:0];
          parallel_sel_q <= (wdata_q[CHAN_W-1:0] == CHAN_PARALLEL);
        end
        if (addr_q == ADR_END_SVC) begin
          eos_pulse_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && phase_rise && state_q == ST_DATA && !is_rd_q && !is_svc_q) begin
      ram_q[ram_idx] <= wdata_q;
    end
  end

  // ============================================================
  // end-of-service hold-off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= '0;
    end else if (ce) begin
      if (eos_pulse_q) begin
        hold_q <= CNT_W'(EOS_CYC);
      end else if (hold_q != '0) begin
        hold_q <= hold_q - CNT_W'(1);
      end
    end
  end

  // ============================================================
  // read data and acknowledge
  logic [DATA_W-1:0] rd_val;
  always_comb begin
    if (is_svc_q) begin
      rd_val = vector_in;
    end else if (addr_q == ADR_CHAN_PTR) begin
      rd_val = DATA_W'(chan_ptr_q);
    end else if (addr_q == ADR_SVC_REQ) begin
      rd_val = svc_req_in;
    end else if (addr_q == ADR_MODEM_IN) begin
      rd_val = modem_in;
    end else begin
      rd_val = ram_q[ram_idx];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp.rdata <= RST_DATA;
      rsp.drive <= 1'b0;
      rsp.ack_n <= 1'b1;
    end else if (ce) begin
      if (state_q == ST_DATA && is_rd_q) begin
        rsp.rdata <= rd_val;
        rsp.drive <= 1'b1;
      end else if (state_q == ST_IDLE) begin
        rsp.drive <= 1'b0;
      end
      if (state_q == ST_ACK || state_q == ST_WAIT) begin
        rsp.ack_n <= strobes_off;
      end else begin
        rsp.ack_n <= 1'b1;
      end
      if ((state_q == ST_ACK || state_q == ST_WAIT) && strobes_off) begin
        rsp.drive <= 1'b0;
      end
    end
  end

  // ============================================================
  // checks
  AST_ACK_AFTER_DATA: assert property (
    @(posedge clk) disable iff (!rstn)
    $fell(rsp.ack_n) && is_rd_q |-> rsp.drive)
    else $error("ack without read data driven");
  AST_NO_ACK_IDLE: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> rsp.ack_n)
    else $error("ack outside a cycle");
  AST_HOLD_BLOCKS: assert property (
    @(posedge clk) disable iff (!rstn)
    hold_q != '0 && state_q == ST_IDLE |=> state_q == ST_IDLE)
    else $error("cycle started during hold-off");
  AST_PHASE: assert property (
    @(posedge clk) disable iff (!rstn)
    phase_rise |=> !phase_rise)
    else $error("divided clock edge two cycles running");
  AST_START_NEEDS_BOTH: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_IDLE ##1 state_q == ST_ADDR |-> $past(sel_now))
    else $error("cycle started with one strobe");
  AST_SEQ: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(state_q == ST_ADDR) |-> ##2 state_q == ST_DATA ##2 state_q == ST_ACK)
    else $error("sequence timing broken");
  AST_HOLD_TILL_OFF: assert property (
    @(posedge clk) disable iff (!rstn)
    !rsp.ack_n && !strobes_off && ce |=> !rsp.ack_n)
    else $error("ack dropped before strobes removed");
  AST_PTR_ROUTE: assert property (
    @(posedge clk) disable iff (!rstn)
    parallel_sel_q == (chan_ptr_q == CHAN_PARALLEL))
    else $error("parallel select disagrees with pointer");
  AST_PTR_LOAD: assert property (
    @(posedge clk) disable iff (!rstn)
    phase_rise && state_q == ST_DATA && !is_rd_q && !is_svc_q &&
    addr_q == ADR_CHAN_PTR |=> chan_ptr_q == $past(wdata_q[CHAN_W-1:0]))
    else $error("channel pointer write not taken");
  AST_DMA_NO_CYCLE: assert property (
    @(posedge clk) disable iff (!rstn)
    state_q == ST_IDLE && !dma_ack_n |=> state_q == ST_IDLE)
    else $error("dma acknowledge opened a register cycle");
endmodule // hbi_host_port
`default_nettype wire

/* verification/hbi_host_model.sv */
// host cpu model: strobed register cycles that wait on transfer acknowledge
// assumes the device answers on the same system clock
`default_nettype none
module hbi_host_model import hbi_pkg::*; (
  input wire logic clk, // system clock
  input wire hbi_rsp_t rsp, // device answer
  output var hbi_req_t req // host strobes, address, write data
);
  timeunit 1ns;
  timeprecision 100ps;
  int lat;
  logic [DATA_W-1:0] rd;
  logic drv;
  initial req = {4'hF, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
  // ==========================================================
  // one cycle; svc picks service-ack in place of select
  // strobes and qualifiers held until ack sampled
  task automatic cyc(input logic svc, input logic rdn, input logic dsn,
                     input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input int lim);
    @(posedge clk);
    #1;
    req.addr = a;
    req.wdata = d;
    req.rd_wr_n = rdn;
    req.cs_n = svc;
    req.svc_ack_n = ~svc;
    req.ds_n = dsn;
    lat = 0;
    // wait states stall the host until acknowledge
    do begin
      @(posedge clk);
      lat++;
    end while (rsp.ack_n !== 1'b0 && lat < lim);
    rd = rsp.rdata;
    drv = rsp.drive;
    #1;
    // both strobes removed to end the cycle
    req.cs_n = 1'b1;
    req.svc_ack_n = 1'b1;
    req.ds_n = 1'b1;
    // released lines do not keep their last value
    req.addr = ~a;
    req.wdata = ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule // hbi_host_model
`default_nettype wire

/* verification/cpu_bus_interface_channel_window_test.sv */
// self-checking bench for the host port, driven through the host model
// assumes a short end-of-service hold-off so the run stays brief
`default_nettype none
module cpu_bus_interface_channel_window_test import hbi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int EOS = 40;
  logic clk = 1'b0, rstn = 1'b0, dma_ack_n = 1'b1, eos_seen = 1'b0;
  logic [DATA_W-1:0] svc_v = 8'hC3, modem_v = 8'h5A, vec_v = 8'h3C;
  hbi_req_t req;
  hbi_rsp_t rsp;
  logic [CHAN_W-1:0] chan_ptr;
  logic par_sel, eos;
  int n_errors = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (eos === 1'b1) eos_seen <= 1'b1;
  hbi_host_model host (.clk(clk), .rsp(rsp), .req(req));
  hbi_host_port #(.EOS_CYC(EOS)) uut (.clk(clk), .rstn(rstn), .ce(1'b1),
    .req(req), .dma_ack_n(dma_ack_n), .dma_in(16'h0000),
    .svc_req_in(svc_v), .modem_in(modem_v), .vector_in(vec_v),
    .rsp(rsp), .chan_ptr_q(chan_ptr), .parallel_sel_q(par_sel),
    .eos_pulse_q(eos));
  // ==========================================================
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t data %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  task automatic t_reset;
    chk1(rsp.ack_n, 1'b1);
    chk1(rsp.drive, 1'b0);
    chk1(par_sel, 1'b1);
  endtask
  // same address lands in a different store for every channel
  task automatic t_window;
    for (int c = 0; c < NUM_CHAN; c++) begin
      host.cyc(1'b0, 1'b0, 1'b0, ADR_CHAN_PTR, 8'(c), 12);
      chk8({6'h00, chan_ptr}, 8'(c));
      chk1(par_sel, c == 0);
      host.cyc(1'b0, 1'b0, 1'b0, 7'h05, 8'hA0 + 8'(c), 12);
    end
    for (int c = NUM_CHAN - 1; c >= 0; c--) begin
      host.cyc(1'b0, 1'b0, 1'b0, ADR_CHAN_PTR, 8'(c), 12);
      host.cyc(1'b0, 1'b1, 1'b0, 7'h05, 8'h00, 12);
      chk8(host.rd, 8'hA0 + 8'(c));
      chk1(host.drv, 1'b1);
      chk1(host.lat >= 4 && host.lat <= 10, 1'b1);
    end
  endtask
  task automatic t_live;
    host.cyc(1'b0, 1'b1, 1'b0, ADR_MODEM_IN, 8'h00, 12);
    chk8(host.rd, 8'h5A);
    host.cyc(1'b0, 1'b1, 1'b0, ADR_SVC_REQ, 8'h00, 12);
    chk8(host.rd, 8'hC3);
    host.cyc(1'b1, 1'b1, 1'b0, ADR_VECTOR, 8'h00, 12);
    chk8(host.rd, 8'h3C);
  endtask
  // a lone select, or a dma acknowledge, must not start a cycle
  task automatic t_refuse;
    host.cyc(1'b0, 1'b1, 1'b1, 7'h05, 8'h00, 20);
    chk1(host.lat == 20, 1'b1);
    chk1(rsp.ack_n, 1'b1);
    #1;
    dma_ack_n = 1'b0;
    host.cyc(1'b0, 1'b1, 1'b0, 7'h05, 8'h00, 20);
    chk1(host.lat == 20, 1'b1);
    chk1(rsp.ack_n, 1'b1);
    @(posedge clk);
    #1;
    dma_ack_n = 1'b1;
  endtask
  task automatic t_eos;
    host.cyc(1'b0, 1'b0, 1'b0, ADR_END_SVC, 8'h00, 12);
    chk1(eos_seen, 1'b1);
    host.cyc(1'b0, 1'b1, 1'b0, ADR_MODEM_IN, 8'h00, 100);
    chk1(host.lat >= EOS && host.lat < EOS + 10, 1'b1);
    chk8(host.rd, 8'h5A);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    rstn = 1'b1;
    t_window();
    t_live();
    t_refuse();
    t_eos();
    tally_and_finish();
  end
  initial begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
endmodule // cpu_bus_interface_channel_window_test
`default_nettype wire
